// ==== hdl/acm_pkg.sv ====
// Constants, field layouts and types shared by the asynchronous memory sequencer
package acm_pkg;

  // ************************************************************
  // Register map, byte offsets on the register bus
  // ************************************************************
  localparam int              ACM_ADR_W        = 8;
  localparam logic [7:0]      ACM_REG_CMD      = 8'h00;
  localparam logic [7:0]      ACM_REG_ADDR     = 8'h04;
  localparam logic [7:0]      ACM_REG_WDATA    = 8'h08;
  localparam logic [7:0]      ACM_REG_RDATA    = 8'h0c;
  localparam logic [7:0]      ACM_REG_STATUS   = 8'h10;
  localparam logic [7:0]      ACM_REG_TIMING   = 8'h20;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int ACM_CMD_START_BIT = 0;
  localparam int ACM_CMD_WRITE_BIT = 1;
  localparam int ACM_CMD_SPACE_LSB = 2;
  localparam int ACM_CMD_SPACE_W   = 2;
  localparam int ACM_CMD_BE_LSB    = 4;
  localparam int ACM_BE_W          = 4;
  localparam int ACM_ADDR_LSB      = 2;
  localparam int ACM_ADDR_W        = 20;
  localparam int ACM_DATA_W        = 32;
  localparam int ACM_NUM_SPACES    = 4;
  localparam int ACM_STAT_BUSY_BIT = 0;
  localparam int ACM_STAT_DONE_BIT = 1;
  localparam int ACM_STAT_RDY_BIT  = 2;
  // Timing word: six counts in memory clock periods
  localparam int ACM_TIM_RS_LSB  = 0;
  localparam int ACM_TIM_RS_W    = 4;
  localparam int ACM_TIM_RST_LSB = 4;
  localparam int ACM_TIM_RST_W   = 6;
  localparam int ACM_TIM_RH_LSB  = 10;
  localparam int ACM_TIM_RH_W    = 3;
  localparam int ACM_TIM_WS_LSB  = 16;
  localparam int ACM_TIM_WS_W    = 4;
  localparam int ACM_TIM_WST_LSB = 20;
  localparam int ACM_TIM_WST_W   = 6;
  localparam int ACM_TIM_WH_LSB  = 26;
  localparam int ACM_TIM_WH_W    = 3;
  localparam logic [31:0] ACM_TIMING_RESET = 32'h04420442;
  localparam int ACM_CNT_W  = 6;
  localparam int ACM_SPAN_W = 8;

  // ************************************************************
  // Sequencer states, Gray coded along idle-setup-strobe-hold
  // ************************************************************
  typedef enum logic [1:0] {
    ACM_IDLE   = 2'b00,
    ACM_SETUP  = 2'b01,
    ACM_STROBE = 2'b11,
    ACM_HOLD   = 2'b10
  } acm_state_t;

  // Extract one count field, a zero count acts as one period
  function automatic logic [ACM_CNT_W-1:0] acm_count(input logic [31:0] word, input int lsb, input int w);
    logic [31:0] f;
    f = (word >> lsb) & ((32'h1 << w) - 32'h1);
    f = (f == 32'h0) ? 32'h1 : f;
    return f[ACM_CNT_W-1:0];
  endfunction : acm_count

endpackage : acm_pkg

// ==== hdl/acm_sync_if.sv ====
// Bundle between the pin synchroniser and the sequencer
`timescale 1ns/1ns
interface acm_sync_if #(parameter int W = 2);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  logic [W-1:0] rise;
  modport sync (input raw, output level, rise);
  modport user (output raw, input level, rise);
endinterface : acm_sync_if

// ==== hdl/acm_pin_sync.sv ====
// Three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ns
module acm_pin_sync
  import acm_pkg::*;
#(
  parameter int W = 2
)(
  // Clock and reset
  input  logic     clk,
  input  logic     rstn,
  // Pins in, clean levels out
  acm_sync_if.sync port
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
    logic [W-1:0] rise;
  } acm_sync_t;

  acm_sync_t r;
  acm_sync_t next_r;

  // Level moves only when the second and third stage agree
  always_comb
  begin
    next_r       = r;
    next_r.s1    = port.raw;
    next_r.s2    = r.s1;
    next_r.s3    = r.s2;
    next_r.level = (r.s2 & r.s3) | (r.level & (r.s2 | r.s3));
    next_r.rise  = next_r.level & ~r.level;
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rstn)
      r <= '0;
    else
      r <= next_r;
  end

  assign port.level = r.level;
  assign port.rise  = r.rise;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking acm_cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_sync_agree_only: assert property (((r.level ^ $past(r.level)) & ($past(r.s2) ^ $past(r.s3))) == '0)
    else $error("Synchronised level moved while stages disagreed");
  a_sync_rise_pulse: assert property ((r.rise != '0) |=> ((r.rise & $past(r.rise)) == '0))
    else $error("Rise pulse lasted longer than one cycle");

endmodule : acm_pin_sync

// ==== hdl/acm_async_mem.sv ====
// Asynchronous memory access sequencer with a classic Wishbone register port
// Function
// - Read: selects valid for read-setup periods before read strobe falls.
// - Read: selects held read-hold periods after read strobe rises.
// - Write: selects and data valid write-setup periods before write strobe falls.
// - Write: selects and data held write-hold periods after write strobe rises.
// - Selects: chip selects, byte enables, word address; writes add data. Output enable falls with the read strobe.
// - Six per-space setup, strobe and hold counts are software programmable.
// - Read data captured at the rising edge of the read strobe.
// - Ready passes a synchroniser and is acted on at a memory clock edge.
// - The shared control pins serve as output enable, read and write strobe.
// - Strobes change only with rising edges of the memory clock output.
// - Memory clock output copies the memory clock input, edge by edge.
`timescale 1ns/1ns
module acm_async_mem
  import acm_pkg::*;
(
  // Clock and reset
  input  logic                                clk,
  input  logic                                rstn,
  // Wishbone slave
  input  logic                                wb_cyc_i,
  input  logic                                wb_stb_i,
  input  logic                                wb_we_i,
  input  logic [ACM_ADR_W-1:0]                wb_adr_i,
  input  logic [3:0]                          wb_sel_i,
  input  logic [ACM_DATA_W-1:0]               wb_dat_i,
  output logic [ACM_DATA_W-1:0]               wb_dat_o,
  output logic                                wb_ack_o,
  // Memory clock
  input  logic                                memory_clock_in,
  output logic                                memory_clock_out,
  // Memory selects and strobes
  output logic [ACM_NUM_SPACES-1:0]           chip_select_n,
  output logic [ACM_BE_W-1:0]                 byte_enable_n,
  output logic [ACM_ADDR_W+ACM_ADDR_LSB-1:ACM_ADDR_LSB] ext_address,
  output logic                                output_enable_n,
  output logic                                read_strobe_n,
  output logic                                write_strobe_n,
  input  logic                                async_ready,
  // Data bus, three signals
  input  logic [ACM_DATA_W-1:0]               ext_data_in,
  output logic [ACM_DATA_W-1:0]               ext_data_out,
  output logic                                ext_data_oe
);

  localparam int SW = ACM_CMD_SPACE_W;

  typedef struct packed {
    acm_state_t                              state;
    logic [ACM_CNT_W-1:0]                    cnt;
    logic                                    pending;
    logic                                    done;
    logic                                    is_write;
    logic [SW-1:0]                           space;
    logic [ACM_BE_W-1:0]                     be;
    logic [ACM_ADDR_W-1:0]                   addr;
    logic [ACM_DATA_W-1:0]                   wdata;
    logic [ACM_DATA_W-1:0]                   rdata;
    logic [ACM_NUM_SPACES-1:0][31:0]         timing;
    logic [ACM_CNT_W-1:0]                    cur_setup;
    logic [ACM_CNT_W-1:0]                    cur_strobe;
    logic [ACM_CNT_W-1:0]                    cur_hold;
    logic [ACM_SPAN_W-1:0]                   span;
    logic                                    mclk;
    logic [ACM_NUM_SPACES-1:0]               cs_n;
    logic [ACM_BE_W-1:0]                     be_n;
    logic [ACM_ADDR_W-1:0]                   ea;
    logic                                    oe_n;
    logic                                    rd_n;
    logic                                    wr_n;
    logic [ACM_DATA_W-1:0]                   dq_out;
    logic                                    dq_oe;
    logic                                    ack;
    logic [ACM_DATA_W-1:0]                   dat;
  } acm_regs_t;

  acm_regs_t r;
  acm_regs_t next_r;

  // ************************************************************
  // Helper functions
  // ************************************************************
  // Aligned word hit on one register offset
  function automatic logic acm_hit(input logic [ACM_ADR_W-1:0] adr, input logic [ACM_ADR_W-1:0] off);
    return adr == off;
  endfunction : acm_hit

  // Byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] acm_merge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        m[i*8 +: 8] = wr[i*8 +: 8];
    return m;
  endfunction : acm_merge

  // Reset image of the whole state
  function automatic acm_regs_t acm_reset_regs();
    acm_regs_t v;
    v        = '0;
    v.cs_n   = '1;
    v.be_n   = '1;
    v.oe_n   = 1'b1;
    v.rd_n   = 1'b1;
    v.wr_n   = 1'b1;
    for (int i = 0; i < ACM_NUM_SPACES; i++)
      v.timing[i] = ACM_TIMING_RESET;
    return v;
  endfunction : acm_reset_regs

  // ************************************************************
  // Synchroniser for memory clock and ready
  // ************************************************************
  acm_sync_if #(.W(2)) pins ();

  // Bit 0 memory clock, bit 1 ready; unclocked ready must stay ~2 periods
  assign pins.raw = {async_ready, memory_clock_in};

  acm_pin_sync #(.W(2)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .port (pins.sync)
  );

  logic tick;
  logic ready;
  assign tick  = pins.rise[0];
  assign ready = pins.level[1];

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    logic                 req;
    logic [31:0]          wcmd;
    logic [31:0]          waddr;
    logic [SW-1:0]        tidx;
    logic                 thit;
    logic [31:0]          tword;
    req    = wb_cyc_i & wb_stb_i;
    wcmd   = '0;
    waddr  = '0;
    tidx   = SW'((wb_adr_i - ACM_REG_TIMING) >> 2);
    thit   = (wb_adr_i >= ACM_REG_TIMING) && (wb_adr_i < ACM_REG_TIMING + 8'(4 * ACM_NUM_SPACES))
             && (wb_adr_i[1:0] == 2'b00);
    tword  = r.timing[r.space];
    next_r = r;

    // Output clock is the synchronised input clock, one flop later
    next_r.mclk = pins.level[0];

    // Bus answer one cycle after the request is seen
    next_r.ack = req & ~r.ack;
    if (req & ~r.ack)
    begin
      next_r.dat = '0;
      if (acm_hit(wb_adr_i, ACM_REG_CMD))
      begin
        next_r.dat[ACM_CMD_WRITE_BIT]                  = r.is_write;
        next_r.dat[ACM_CMD_SPACE_LSB +: SW]            = r.space;
        next_r.dat[ACM_CMD_BE_LSB +: ACM_BE_W]         = r.be;
      end
      if (acm_hit(wb_adr_i, ACM_REG_ADDR))
        next_r.dat[ACM_ADDR_LSB +: ACM_ADDR_W] = r.addr;
      if (acm_hit(wb_adr_i, ACM_REG_WDATA))
        next_r.dat = r.wdata;
      if (acm_hit(wb_adr_i, ACM_REG_RDATA))
        next_r.dat = r.rdata;
      if (acm_hit(wb_adr_i, ACM_REG_STATUS))
      begin
        next_r.dat[ACM_STAT_BUSY_BIT] = r.pending | (r.state != ACM_IDLE);
        next_r.dat[ACM_STAT_DONE_BIT] = r.done;
        next_r.dat[ACM_STAT_RDY_BIT]  = ready;
      end
      if (thit)
        next_r.dat = r.timing[tidx];
    end

    // Register writes take effect at the acknowledged edge
    if (req & wb_we_i & r.ack)
    begin
      if (thit)
        next_r.timing[tidx] = acm_merge(r.timing[tidx], wb_dat_i, wb_sel_i);
      if (acm_hit(wb_adr_i, ACM_REG_WDATA))
        next_r.wdata = acm_merge(r.wdata, wb_dat_i, wb_sel_i);
      if (acm_hit(wb_adr_i, ACM_REG_ADDR))
      begin
        waddr       = acm_merge({10'h000, r.addr, 2'b00}, wb_dat_i, wb_sel_i);
        next_r.addr = waddr[ACM_ADDR_LSB +: ACM_ADDR_W];
      end
      if (acm_hit(wb_adr_i, ACM_REG_CMD) && (r.state == ACM_IDLE) && !r.pending)
      begin
        wcmd = acm_merge({24'h000000, r.be, r.space, r.is_write, 1'b0}, wb_dat_i, wb_sel_i);
        next_r.is_write = wcmd[ACM_CMD_WRITE_BIT];
        next_r.space    = wcmd[ACM_CMD_SPACE_LSB +: SW];
        next_r.be       = wcmd[ACM_CMD_BE_LSB +: ACM_BE_W];
        if (wcmd[ACM_CMD_START_BIT])
        begin
          next_r.pending = 1'b1;
          next_r.done    = 1'b0;
        end
      end
    end

    // Access sequencer, advances only on memory clock rising edges
    if (tick)
    begin
      case (r.state)
        ACM_IDLE:
        begin
          if (r.pending)
          begin
            // Present all selects; output enable stays high until the strobe
            next_r.pending    = 1'b0;
            next_r.cs_n       = ~(ACM_NUM_SPACES'(1) << r.space);
            next_r.be_n       = ~r.be;
            next_r.ea         = r.addr;
            next_r.oe_n       = 1'b1;
            next_r.dq_out     = r.wdata;
            next_r.dq_oe      = r.is_write;
            next_r.cur_setup  = r.is_write ? acm_count(tword, ACM_TIM_WS_LSB, ACM_TIM_WS_W)
                                           : acm_count(tword, ACM_TIM_RS_LSB, ACM_TIM_RS_W);
            next_r.cur_strobe = r.is_write ? acm_count(tword, ACM_TIM_WST_LSB, ACM_TIM_WST_W)
                                           : acm_count(tword, ACM_TIM_RST_LSB, ACM_TIM_RST_W);
            next_r.cur_hold   = r.is_write ? acm_count(tword, ACM_TIM_WH_LSB, ACM_TIM_WH_W)
                                           : acm_count(tword, ACM_TIM_RH_LSB, ACM_TIM_RH_W);
            next_r.cnt        = next_r.cur_setup;
            next_r.state      = ACM_SETUP;
          end
        end
        ACM_SETUP:
        begin
          if (r.cnt <= ACM_CNT_W'(1))
          begin
            // Setup spent: drop the strobe on the shared control pin
            next_r.rd_n  = r.is_write;
            next_r.wr_n  = ~r.is_write;
            next_r.oe_n  = r.is_write;
            next_r.cnt   = r.cur_strobe;
            next_r.state = ACM_STROBE;
          end
          else
            next_r.cnt = r.cnt - ACM_CNT_W'(1);
        end
        ACM_STROBE:
        begin
          if (r.cnt > ACM_CNT_W'(1))
            next_r.cnt = r.cnt - ACM_CNT_W'(1);
          else if (ready)
          begin
            next_r.rd_n  = 1'b1;
            next_r.wr_n  = 1'b1;
            next_r.oe_n  = 1'b1;
            if (!r.is_write)
              next_r.rdata = ext_data_in;
            next_r.cnt   = r.cur_hold;
            next_r.state = ACM_HOLD;
          end
        end
        ACM_HOLD:
        begin
          if (r.cnt <= ACM_CNT_W'(1))
          begin
            // Hold spent: release chip selects, byte enables and the data bus; the address keeps its value
            next_r.cs_n  = '1;
            next_r.be_n  = '1;
            next_r.dq_oe = 1'b0;
            next_r.done  = 1'b1;
            next_r.state = ACM_IDLE;
          end
          else
            next_r.cnt = r.cnt - ACM_CNT_W'(1);
        end
        default:
          next_r.state = ACM_IDLE;
      endcase
    end

    // Periods since the last select or strobe change
    if ((next_r.cs_n != r.cs_n) || (next_r.rd_n != r.rd_n) || (next_r.wr_n != r.wr_n))
      next_r.span = '0;
    else if (tick)
      next_r.span = r.span + ACM_SPAN_W'(1);
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rstn)
      r <= acm_reset_regs();
    else
      r <= next_r;
  end

  // Outputs straight from the state register
  assign wb_dat_o         = r.dat;
  assign wb_ack_o         = r.ack;
  assign memory_clock_out = r.mclk;
  assign chip_select_n    = r.cs_n;
  assign byte_enable_n    = r.be_n;
  assign ext_address      = r.ea;
  assign output_enable_n  = r.oe_n;
  assign read_strobe_n    = r.rd_n;
  assign write_strobe_n   = r.wr_n;
  assign ext_data_out     = r.dq_out;
  assign ext_data_oe      = r.dq_oe;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking acm_cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_strobe_rise;
    $rose(r.rd_n) || $rose(r.wr_n);
  endsequence
  sequence s_cs_release;
    $rose(&r.cs_n);
  endsequence

  a_read_setup_span: assert property ($fell(r.rd_n) |-> ($past(r.span) + 8'h01) == ACM_SPAN_W'(r.cur_setup))
    else $error("Read setup span differs from programmed count");
  a_read_hold_span: assert property (s_cs_release and !r.is_write |-> ($past(r.span) + 8'h01) == ACM_SPAN_W'(r.cur_hold))
    else $error("Read hold span differs from programmed count");
  a_write_setup_span: assert property ($fell(r.wr_n) |-> ($past(r.span) + 8'h01) == ACM_SPAN_W'(r.cur_setup))
    else $error("Write setup span differs from programmed count");
  a_write_hold_span: assert property (s_cs_release and r.is_write |-> ($past(r.span) + 8'h01) == ACM_SPAN_W'(r.cur_hold))
    else $error("Write hold span differs from programmed count");
  a_write_data_stable: assert property (r.dq_oe && $past(r.dq_oe) |-> $stable(r.dq_out) && $stable(r.ea) && $stable(r.cs_n))
    else $error("Write selects or data moved during the access");
  a_strobe_on_edge: assert property ($changed(r.rd_n) || $changed(r.wr_n) |-> $rose(r.mclk))
    else $error("Strobe changed away from a memory clock rising edge");
  a_clock_follows: assert property ($rose(pins.level[0]) |=> $rose(r.mclk) ##1 r.mclk)
    else $error("Memory clock output did not follow its input");
  a_oe_read_only: assert property ((!r.wr_n |-> r.oe_n) and (!r.rd_n |-> !r.oe_n))
    else $error("Output enable wrong for the access direction");
  a_strobe_min_width: assert property (s_strobe_rise |->
                                       ($past(r.span) + 8'h01) >= ACM_SPAN_W'(r.cur_strobe))
    else $error("Strobe shorter than its programmed count");
  a_ready_extend: assert property ((r.state == ACM_STROBE) && tick && (r.cnt <= 6'h01) && !ready
                                   |=> (r.state == ACM_STROBE) && (!r.rd_n || !r.wr_n))
    else $error("Strobe ended while ready was low");
  a_read_capture: assert property ($rose(r.rd_n) |-> r.rdata == $past(ext_data_in))
    else $error("Read data not captured at the strobe rising edge");

endmodule : acm_async_mem

// ==== tb/acm_mem_model.sv ====
// Behavioural asynchronous memory facing the sequencer pins
`timescale 1ns/1ns
module acm_mem_model
  import acm_pkg::*;
(
  // Selects and strobes
  input  logic [3:0]  chip_select_n,
  input  logic [3:0]  byte_enable_n,
  input  logic [21:2] ext_address,
  input  logic        output_enable_n,
  input  logic        read_strobe_n,
  input  logic        write_strobe_n,
  input  logic        memory_clock_out,
  // Data bus and ready
  input  logic [31:0] ext_data_out,
  input  logic        ext_data_oe,
  output logic [31:0] ext_data_in,
  output logic        async_ready,
  // Ready stall length in memory clock periods
  input  logic [7:0]  stall
);
  logic [31:0] mem [256];
  logic [7:0]  idx;
  // Space index and word slot of the selected location
  always_comb
  begin
    idx = {2'h0, ext_address[7:2]};
    for (int i = 0; i < 4; i++)
      if (!chip_select_n[i]) idx[7:6] = i[1:0];
  end
  // Bus carries data only while output enable is low, else inverted data
  assign ext_data_in = output_enable_n ? ~mem[idx] : mem[idx];
  // Store enabled lanes as the write strobe returns high
  always @(posedge write_strobe_n)
    if (ext_data_oe === 1'b1)
      for (int b = 0; b < 4; b++)
        if (!byte_enable_n[b]) mem[idx][8*b+:8] = ext_data_out[8*b+:8];
  // Empty memory, ready high
  initial
  begin
    async_ready = 1'b1;
    for (int i = 0; i < 256; i++) mem[i] = 32'h0;
  end
  // Ready low for whole memory clock periods after a strobe falls
  always @(negedge read_strobe_n or negedge write_strobe_n)
    if (stall != 8'h0)
    begin
      async_ready = 1'b0;
      repeat (stall) @(posedge memory_clock_out);
      async_ready = 1'b1;
    end
endmodule : acm_mem_model

// ==== tb/tb_top.sv ====
// Self-checking bench of the asynchronous memory sequencer
`timescale 1ns/1ns
module tb_top
  import acm_pkg::*;
;
  typedef struct {int su; int st; int ho; logic [19:0] adr; logic [3:0] csn; logic [3:0] ben; logic wr;
                  logic [31:0] dat;} acm_exp_t;
  logic        clk, rstn, cyc, stb, we, ack, mclk_in, mclk_out, oen, rdn, wrn, rdy, doe, pm, prd, pwr;
  logic [7:0]  adr, stall;
  logic [3:0]  sel, csn, ben, pcs;
  logic [31:0] wdat, rdat, din, dout, r, x, tim, seed;
  logic [21:2] ea;
  logic [31:0] shd [256];
  acm_exp_t    q [$];
  acm_exp_t    cur;
  int          fails, total_checks, cnt, su, st;
  // ************************************************************
  // Design and far-side memory
  // ************************************************************
  acm_async_mem DUT (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .memory_clock_in(mclk_in),
    .memory_clock_out(mclk_out), .chip_select_n(csn), .byte_enable_n(ben), .ext_address(ea),
    .output_enable_n(oen), .read_strobe_n(rdn), .write_strobe_n(wrn), .async_ready(rdy),
    .ext_data_in(din), .ext_data_out(dout), .ext_data_oe(doe));
  acm_mem_model MEM (.chip_select_n(csn), .byte_enable_n(ben), .ext_address(ea), .output_enable_n(oen),
    .read_strobe_n(rdn), .write_strobe_n(wrn), .memory_clock_out(mclk_out), .ext_data_out(dout),
    .ext_data_oe(doe), .ext_data_in(din), .async_ready(rdy), .stall(stall));
  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // Count field, zero acts as one period
  function automatic int fl(input logic [31:0] w, input int lsb, input int wd);
    int f;
    f = int'((w >> lsb) & ((32'h1 << wd) - 32'h1));
    return (f == 0) ? 1 : f;
  endfunction : fl
  // Classic Wishbone cycle, ack and read data taken at a rising edge, released at that same edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fails++;
      end_sim();
    end
    rd = rdat;
    {cyc, stb} <= 2'b00;
  endtask : wb
  // One memory access with its expected pin timing noted for the monitor
  task automatic acc(input logic [1:0] sp, input logic w, input logic [19:0] a, input logic [31:0] d,
                     input logic [3:0] be, input logic [7:0] stl);
    acm_exp_t e;
    logic [7:0] ix;
    int k;
    e = '{fl(tim, w ? ACM_TIM_WS_LSB : ACM_TIM_RS_LSB, w ? ACM_TIM_WS_W : ACM_TIM_RS_W),
          fl(tim, w ? ACM_TIM_WST_LSB : ACM_TIM_RST_LSB, w ? ACM_TIM_WST_W : ACM_TIM_RST_W),
          fl(tim, w ? ACM_TIM_WH_LSB : ACM_TIM_RH_LSB, w ? ACM_TIM_WH_W : ACM_TIM_RH_W),
          a, ~(4'h1 << sp), ~be, w, d};
    if (stl != 8'h0 && int'(stl) + 1 > e.st) e.st = int'(stl) + 1;
    stall <= stl;
    q.push_back(e);
    wb(1'b1, ACM_REG_TIMING + {4'h0, sp, 2'h0}, tim, r);
    wb(1'b1, ACM_REG_ADDR, {10'h0, a, 2'h0}, r);
    wb(1'b1, ACM_REG_WDATA, d, r);
    wb(1'b1, ACM_REG_CMD, {24'h0, be, sp, w, 1'b1}, r);
    k = 0;
    do begin wb(1'b0, ACM_REG_STATUS, 32'h0, r); k++; end while (r[0] !== 1'b0 && k < 3000);
    check("done", r[1], 32'h1);
    ix = {sp, a[5:0]};
    for (int b = 0; b < 4; b++)
      if (w && be[b]) shd[ix][8*b+:8] = d[8*b+:8];
    if (!w) wb(1'b0, ACM_REG_RDATA, 32'h0, r);
    if (!w) check("rdata", r, shd[ix]);
  endtask : acc
  // ************************************************************
  // Clocks, watchdog, pin monitor
  // ************************************************************
  initial begin clk = 1'b0; forever #2 clk = ~clk; end
  initial begin mclk_in = 1'b0; forever begin #62 mclk_in = 1'b1; #63 mclk_in = 1'b0; end end
  initial begin #400000; fails++; end_sim(); end
  // Pin timing counted in memory clock rising edges, compared with oldest note
  always @(negedge clk)
  begin
    if (rstn === 1'b1)
    begin
      if (mclk_out && !pm) cnt++;
      if (mclk_out && !pm) check("clk_follow", mclk_in, 32'h1);
      if ({rdn, wrn, csn} !== {prd, pwr, pcs}) check("on_edge", mclk_out && !pm, 32'h1);
      check("oe_read", oen, rdn);
      if (pcs == 4'hf && csn != 4'hf) check("queued", q.size(), 32'h1);
      if (pcs == 4'hf && csn != 4'hf) begin cur = q.pop_front(); cnt = 0; end
      if (csn != 4'hf) check("addr", {ea, 2'h0}, {cur.adr, 2'h0});
      if (csn != 4'hf) check("sel", {csn, ben, doe}, {cur.csn, cur.ben, cur.wr});
      if (csn != 4'hf && cur.wr) check("wdata", dout, cur.dat);
      if (csn != 4'hf) check("kind", cur.wr ? rdn : wrn, 32'h1);
      if ((!rdn && prd) || (!wrn && pwr)) begin su = cnt; cnt = 0; end
      if ((rdn && !prd) || (wrn && !pwr)) begin st = cnt; cnt = 0; end
      if (csn == 4'hf && pcs != 4'hf) check("setup", su, cur.su);
      if (csn == 4'hf && pcs != 4'hf) check("strobe", st, cur.st);
      if (csn == 4'hf && pcs != 4'hf) check("hold", cnt, cur.ho);
    end
    {pm, prd, pwr, pcs} = {mclk_out, rdn, wrn, csn};
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    {rstn, cyc, stb, we, adr, sel, wdat, stall, seed} = {3'b000, 1'b0, 8'h0, 4'h0, 32'h0, 8'h0, 32'h0000000b};
    for (int i = 0; i < 256; i++) shd[i] = 32'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check("idle", {csn, ben, oen, rdn, wrn, doe}, {4'hf, 4'hf, 4'he});
    wb(1'b0, ACM_REG_TIMING, 32'h0, r);
    check("tim_reset", r, ACM_TIMING_RESET);
    wb(1'b0, 8'h44, 32'h0, r);
    check("unmapped", r, 32'h0);
    wb(1'b0, ACM_REG_STATUS, 32'h0, r);
    check("status_idle", r, 32'h1 << ACM_STAT_RDY_BIT);
    $display("test reset done");
    for (int i = 0; i < 12; i++)
    begin
      x = xs();
      tim = (i == 0) ? ACM_TIMING_RESET : (i == 1) ? 32'h0 : (xs() & 32'h1cff1cff);
      // Every ready stall lasts at least two memory clock periods
      acc(x[1:0], 1'b1, x[21:2], xs(), x[25:22] | 4'h1,
          (i % 3 == 2) ? 8'h12 : (i % 3 == 1) ? 8'h02 : 8'h00);
      acc(x[1:0], 1'b0, x[21:2], 32'h0, 4'hf, (i % 3 == 2) ? 8'h12 : 8'h00);
      $display("test %0d done", i);
    end
    end_sim();
  end
endmodule : tb_top
